// ---- design/jk_toggle_sr_flip_flops.sv ----
// JK, toggle and set-reset flops with delays behind an AXI4-Lite slave
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "jk_toggle_sr_map.svh"

module jk_toggle_sr_flip_flops (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Flop pins, bit 0 JK, bit 1 toggle, bit 2 set-reset
  input wire logic [2:0] i_flop_clk,
  input wire logic [2:0] i_data_a,
  input wire logic [2:0] i_data_b,
  input wire logic [2:0] i_async_set,
  input wire logic [2:0] i_async_reset,
  input wire logic [2:0] i_ctl_unknown,
  output logic [2:0] o_out,
  output logic [2:0] o_out_n,
  output logic [2:0] o_out_unknown,
  // AXI4-Lite write channels
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready
);

  // Bus slave state
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] cfg_q [3];
  logic [31:0] cfg_d [3];
  logic [5:0] init_q, init_d;
  logic init_load_q, init_load_d;
  logic [2:0] busy;
  logic do_write;

  // Handshake readies, one write and one read at a time
  assign o_axi_awready = !aw_held_q && !bvalid_q;
  assign o_axi_wready = !w_held_q && !bvalid_q;
  assign o_axi_arready = !rvalid_q;
  assign o_axi_bvalid = bvalid_q;
  assign o_axi_bresp = bresp_q;
  assign o_axi_rvalid = rvalid_q;
  assign o_axi_rresp = rresp_q;
  assign o_axi_rdata = rdata_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  // Bus next state: capture, decode, answer
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    cfg_d = cfg_q;
    init_d = init_q;
    init_load_d = 1'b0;
    if (i_axi_awvalid && o_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d = i_axi_awaddr;
    end
    if (i_axi_wvalid && o_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d = i_axi_wdata;
      wstrb_d = i_axi_wstrb;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `RESP_OKAY;
      case (awaddr_q)
        `CFG_JK_OFS, `CFG_TOGGLE_OFS, `CFG_SR_OFS: begin
          for (int b = 0; b < 4; b++) begin
            if (wstrb_q[b]) begin
              cfg_d[awaddr_q[3:2]][b*8 +: 8] = wdata_q[b*8 +: 8];
            end
          end
        end
        `INIT_OFS: begin
          if (wstrb_q[0]) begin
            init_d = wdata_q[5:0];
            init_load_d = 1'b1;
          end
        end
        `STATUS_OFS: begin
          bresp_d = `RESP_OKAY;
        end
        default: begin
          bresp_d = `RESP_SLVERR;
        end
      endcase
    end else if (bvalid_q && i_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (i_axi_arvalid && o_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = `RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (i_axi_araddr)
        `CFG_JK_OFS: rdata_d = cfg_q[0];
        `CFG_TOGGLE_OFS: rdata_d = cfg_q[1];
        `CFG_SR_OFS: rdata_d = cfg_q[2];
        `INIT_OFS: rdata_d = {26'h0, init_q};
        `STATUS_OFS: begin
          rdata_d[`STAT_OUT_LSB +: 3] = o_out;
          rdata_d[`STAT_UNK_LSB +: 3] = o_out_unknown;
          rdata_d[`STAT_BUSY_LSB +: 3] = busy;
        end
        default: rresp_d = `RESP_SLVERR;
      endcase
    end else if (rvalid_q && i_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Bus registers
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      cfg_q[0] <= `CFG_RESET;
      cfg_q[1] <= `CFG_RESET;
      cfg_q[2] <= `CFG_RESET;
      init_q <= `INIT_RESET;
      init_load_q <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      cfg_q <= cfg_d;
      init_q <= init_d;
      init_load_q <= init_load_d;
    end
  end

  // One flop of each kind
  for (genvar v = 0; v < 3; v++) begin : g_flop
    logic [5:0] sync1_q, sync2_q;
    logic clk_prev_q;
    flop_pkg::level_t stored_q, stored_d;
    flop_pkg::level_t out_q, out_d;
    flop_pkg::level_t pend_q, pend_d;
    flop_pkg::dly_state_t st_q, st_d;
    logic [8:0] cnt_q, cnt_d;

    // Pin synchronisers; edge detector reads only the second stage
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        sync1_q <= 6'h00;
        sync2_q <= 6'h00;
        clk_prev_q <= 1'b0;
      end else begin
        sync1_q <= {i_ctl_unknown[v], i_async_reset[v], i_async_set[v],
                    i_data_b[v], i_data_a[v], i_flop_clk[v]};
        sync2_q <= sync1_q;
        clk_prev_q <= sync2_q[0];
      end
    end

    // Next stored level, path delay and output timing
    always_comb begin
      flop_pkg::level_t inv;
      flop_pkg::level_t clk_val;
      flop_pkg::level_t nv;
      logic [7:0] dly;
      logic [3:0] ext;
      logic ev;
      inv = flop_pkg::LEVEL_UNKNOWN;
      clk_val = stored_q;
      nv = stored_q;
      dly = 8'h00;
      ext = 4'h0;
      ev = 1'b0;
      stored_d = stored_q;
      out_d = out_q;
      pend_d = pend_q;
      st_d = st_q;
      cnt_d = cnt_q;
      if (stored_q == flop_pkg::LEVEL_LOW) begin
        inv = flop_pkg::LEVEL_HIGH;
      end else if (stored_q == flop_pkg::LEVEL_HIGH) begin
        inv = flop_pkg::LEVEL_LOW;
      end
      // Value taken at a rising clock edge
      if (v == 1) begin
        clk_val = sync2_q[1] ? inv : stored_q;
      end else begin
        case (sync2_q[2:1])
          2'b00: clk_val = stored_q;
          2'b10: clk_val = flop_pkg::LEVEL_LOW;
          2'b01: clk_val = flop_pkg::LEVEL_HIGH;
          2'b11: clk_val = (v == 0) ? inv : flop_pkg::LEVEL_UNKNOWN;
          default: clk_val = stored_q;
        endcase
      end
      // Pending output change counts down
      case (st_q)
        flop_pkg::DLY_IDLE: st_d = flop_pkg::DLY_IDLE;
        flop_pkg::DLY_WAIT: begin
          if (cnt_q <= 9'h001) begin
            out_d = pend_q;
            st_d = flop_pkg::DLY_IDLE;
          end else begin
            cnt_d = cnt_q - 9'h001;
          end
        end
        default: st_d = flop_pkg::DLY_IDLE;
      endcase
      // Cause of a change, asynchronous controls first
      if (sync2_q[4]) begin
        ev = 1'b1;
        nv = sync2_q[3] ? flop_pkg::LEVEL_UNKNOWN : flop_pkg::LEVEL_LOW;
        dly = cfg_q[v][`RST_DLY_LSB +: 8];
      end else if (sync2_q[3]) begin
        ev = 1'b1;
        nv = flop_pkg::LEVEL_HIGH;
        dly = cfg_q[v][`SET_DLY_LSB +: 8];
      end else if (sync2_q[0] && !clk_prev_q) begin
        ev = 1'b1;
        nv = clk_val;
        dly = cfg_q[v][`CLK_DLY_LSB +: 8];
      end
      if (nv == flop_pkg::LEVEL_HIGH) begin
        ext = cfg_q[v][`RISE_LSB +: 4];
      end else if (nv == flop_pkg::LEVEL_LOW) begin
        ext = cfg_q[v][`FALL_LSB +: 4];
      end
      if (dly < 8'(`DELAY_MIN_CYC)) begin
        dly = 8'(`DELAY_MIN_CYC);
      end
      if (ev && nv != stored_q) begin
        stored_d = nv;
        pend_d = nv;
        cnt_d = {1'b0, dly} + {5'h00, ext};
        st_d = flop_pkg::DLY_WAIT;
      end
      // Unknown control level overrides at once
      if (sync2_q[5]) begin
        stored_d = flop_pkg::LEVEL_UNKNOWN;
        out_d = flop_pkg::LEVEL_UNKNOWN;
        st_d = flop_pkg::DLY_IDLE;
      end
      // Software reload of the initial state
      if (init_load_q) begin
        case (init_q[v*2 +: 2])
          2'h1: stored_d = flop_pkg::LEVEL_HIGH;
          2'h2: stored_d = flop_pkg::LEVEL_UNKNOWN;
          default: stored_d = flop_pkg::LEVEL_LOW;
        endcase
        out_d = stored_d;
        st_d = flop_pkg::DLY_IDLE;
      end
    end

    // Flop state registers
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        stored_q <= flop_pkg::LEVEL_LOW;
        out_q <= flop_pkg::LEVEL_LOW;
        pend_q <= flop_pkg::LEVEL_LOW;
        st_q <= flop_pkg::DLY_IDLE;
        cnt_q <= 9'h000;
      end else begin
        stored_q <= stored_d;
        out_q <= out_d;
        pend_q <= pend_d;
        st_q <= st_d;
        cnt_q <= cnt_d;
      end
    end

    // Outputs decoded from the output level register
    assign o_out[v] = (out_q == flop_pkg::LEVEL_HIGH);
    assign o_out_n[v] = (out_q == flop_pkg::LEVEL_LOW);
    assign o_out_unknown[v] = (out_q == flop_pkg::LEVEL_UNKNOWN);
    assign busy[v] = (st_q == flop_pkg::DLY_WAIT);
  end

endmodule : jk_toggle_sr_flip_flops

// ---- inc/flop_pkg.sv ----
// Types shared by the flip-flop set
package flop_pkg;

  // Stored level of one flop
  typedef enum logic [1:0] {
    LEVEL_LOW = 2'b00,
    LEVEL_HIGH = 2'b01,
    LEVEL_UNKNOWN = 2'b10
  } level_t;

  // Output delay state
  typedef enum logic [0:0] {
    DLY_IDLE = 1'b0,
    DLY_WAIT = 1'b1
  } dly_state_t;

endpackage : flop_pkg

// ---- inc/jk_toggle_sr_map.svh ----
// Register map, field positions, reset values and timing constants
// What this block does
// - JK flop holds one bit, updating only on rising clock, per j and k.
// - Toggle flop inverts its stored bit on a rising clock edge while data a is high, else holds it.
// - Set-reset flop captures only on rising clock edges.
// - Set-reset flop's captured value follows the s and r levels.
// - Every flop has asynchronous set and reset that need no clock edge.
// - Separate clock, set, reset delays; default 1 ns, at least 1 ps. Here counted in 25 ns clock cycles, default and minimum 1 cycle.
// - Rise or fall delay is added to the delay of the causing path.
// - True and inverted outputs; inverted is the complement except when unknown, then both are low.
// - Initial output state is a code 0 to 2, default 0.
// - JK: unknown clock, set or reset makes output unknown; j, k not.
// - Toggle: unknown clock, set or reset makes output unknown at once.
// - Set-reset: unknown clock, set or reset gives unknown output at once.
`ifndef JK_TOGGLE_SR_MAP_SVH
`define JK_TOGGLE_SR_MAP_SVH

// Register byte offsets
`define CFG_JK_OFS 8'h00
`define CFG_TOGGLE_OFS 8'h04
`define CFG_SR_OFS 8'h08
`define INIT_OFS 8'h0C
`define STATUS_OFS 8'h10

// Configuration fields
`define CLK_DLY_LSB 0
`define SET_DLY_LSB 8
`define RST_DLY_LSB 16
`define RISE_LSB 24
`define FALL_LSB 28

// Status fields
`define STAT_OUT_LSB 0
`define STAT_UNK_LSB 4
`define STAT_BUSY_LSB 8

// Timing in picoseconds and derived cycle counts
`define CLK_PERIOD_PS 25000
`define DELAY_DEF_PS 1000
`define DELAY_MIN_PS 1
`define DELAY_DEF_CYC ((`DELAY_DEF_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DELAY_MIN_CYC ((`DELAY_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// Reset values
`define CFG_RESET 32'h0001_0101
`define INIT_RESET 6'h00

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- verification/flop_assertions.sv ----
// Port-level checks for the flop set and its register bus
`timescale 1ns/1ps
module flop_assertions (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Flop pins
  input wire logic [2:0] i_ctl_unknown,
  input wire logic [2:0] o_out,
  input wire logic [2:0] o_out_n,
  input wire logic [2:0] o_out_unknown,
  // Register bus
  input wire logic i_axi_awvalid,
  input wire logic o_axi_awready,
  input wire logic i_axi_wvalid,
  input wire logic o_axi_wready,
  input wire logic [1:0] o_axi_bresp,
  input wire logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic i_axi_arvalid,
  input wire logic o_axi_arready,
  input wire logic [31:0] o_axi_rdata,
  input wire logic o_axi_rvalid,
  input wire logic i_axi_rready
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Handshakes that start a response
  sequence s_wr_take;
    i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready;
  endsequence
  sequence s_rd_take;
    i_axi_arvalid && o_axi_arready;
  endsequence
  // Output pair and unknown flag
  property p_cmpl; ((o_out ^ o_out_n) | o_out_unknown) == 3'h7; endproperty
  a_cmpl: assert property (p_cmpl) else $error("inverse mismatch");
  property p_zero; (o_out_unknown & (o_out | o_out_n)) == 3'h0; endproperty
  a_zero: assert property (p_zero) else $error("unknown not zero");
  property p_unk; (&i_ctl_unknown) [*5] |-> (&o_out_unknown); endproperty
  a_unk: assert property (p_unk) else $error("no unknown");
  // Bus answers and holds; the write acts one edge after both are taken
  property p_wans; s_wr_take |-> ##2 o_axi_bvalid; endproperty
  a_wans: assert property (p_wans) else $error("late write answer");
  property p_rans; s_rd_take |=> o_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("late read answer");
  property p_bhold;
    o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_blk; o_axi_rvalid |-> !o_axi_arready; endproperty
  a_blk: assert property (p_blk) else $error("read taken while busy");
endmodule : flop_assertions

bind jk_toggle_sr_flip_flops flop_assertions chk (.*);

// ---- verification/jk_toggle_sr_flip_flops_tb.sv ----
// Self-checking bench for the JK, toggle and set-reset flops
`timescale 1ns/1ps
`include "jk_toggle_sr_map.svh"
module jk_toggle_sr_flip_flops_tb;
  // Stimulus tables: data a, data b, edge mask, expected outputs
  localparam logic [2:0] TA [6] = '{3'h5, 3'h0, 3'h3, 3'h3, 3'h0, 3'h7};
  localparam logic [2:0] TB [6] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h5, 3'h0};
  localparam logic [2:0] TF [6] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h0};
  localparam logic [2:0] TE [6] = '{3'h5, 3'h5, 3'h6, 3'h5, 3'h0, 3'h0};
  localparam logic [2:0] AS [5] = '{3'h7, 3'h0, 3'h7, 3'h0, 3'h0};
  localparam logic [2:0] AR [5] = '{3'h0, 3'h7, 3'h7, 3'h0, 3'h0};
  localparam logic [2:0] AU [5] = '{3'h0, 3'h0, 3'h0, 3'h7, 3'h0};
  localparam logic [5:0] AE [5] = '{6'h07, 6'h00, 6'h38, 6'h38, 6'h38};
  // Design pins and bench state
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic [2:0] i_data_a = 3'h0, i_data_b = 3'h0, i_async_set = 3'h0;
  logic [2:0] i_async_reset = 3'h0, i_ctl_unknown = 3'h0, fire = 3'h0;
  logic [2:0] i_flop_clk, o_out, o_out_n, o_out_unknown;
  logic [7:0] i_axi_awaddr = 8'h00, i_axi_araddr = 8'h00;
  logic [31:0] i_axi_wdata = 32'h0, o_axi_rdata, rd_q;
  logic [3:0] i_axi_wstrb = 4'hF, hold = 4'h2;
  logic i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
  logic i_axi_arvalid = 1'b0, i_axi_rready = 1'b0, o_axi_awready;
  logic o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
  logic [1:0] o_axi_bresp, o_axi_rresp, resp;
  int error_cnt = 0, n_tests = 0, lat0, lat;
  always #12.5 i_clock = ~i_clock;
  jk_toggle_sr_flip_flops DUT (.*);
  pin_driver drv (.i_clock(i_clock), .i_fire(fire), .i_hold(hold),
    .o_flop_clk(i_flop_clk));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // Register write; each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clock);
    i_axi_awaddr <= a;
    i_axi_wdata <= d;
    i_axi_awvalid <= 1'b1;
    i_axi_wvalid <= 1'b1;
    i_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clock);
      if (i_axi_awvalid && o_axi_awready) i_axi_awvalid <= 1'b0;
      if (i_axi_wvalid && o_axi_wready) i_axi_wvalid <= 1'b0;
      if (o_axi_bvalid) break;
    end
    resp = o_axi_bresp;
    i_axi_bready <= 1'b0;
    if (n == 50) begin
      error_cnt++;
      summarize();
    end
  endtask : wr
  // Register read into rd_q and resp, taken at the answering edge
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge i_clock);
    i_axi_araddr <= a;
    i_axi_arvalid <= 1'b1;
    i_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clock);
      if (i_axi_arvalid && o_axi_arready) i_axi_arvalid <= 1'b0;
      if (o_axi_rvalid) break;
    end
    rd_q = o_axi_rdata;
    resp = o_axi_rresp;
    i_axi_rready <= 1'b0;
    if (n == 50) begin
      error_cnt++;
      summarize();
    end
  endtask : rd
  // One flop clock pulse with its data levels, all set on a rising edge
  task automatic pulse(input logic [2:0] m, input logic [2:0] a,
                       input logic [2:0] b);
    @(posedge i_clock);
    i_data_a <= a;
    i_data_b <= b;
    fire <= m;
    @(posedge i_clock);
    fire <= 3'h0;
  endtask : pulse
  // Pulse and count clock cycles until the masked outputs change
  task automatic meas(input logic [2:0] m, input logic [2:0] a,
                      input logic [2:0] b, output int n);
    logic [2:0] s;
    s = o_out;
    pulse(m, a, b);
    for (n = 1; n < 300 && (o_out & m) === (s & m); n++) begin
      @(negedge i_clock);
    end
    if (n == 300) begin
      error_cnt++;
      summarize();
    end
    repeat (12) @(negedge i_clock);
  endtask : meas
  // Main sequence
  initial begin
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
    rd(`CFG_JK_OFS);
    check(rd_q, `CFG_RESET);
    rd(8'h20);
    check({30'h0, resp}, {30'h0, `RESP_SLVERR});
    check({29'h0, o_out_n}, 32'h7);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      pulse(TF[i], TA[i], TB[i]);
      repeat (12) @(negedge i_clock);
      check({29'h0, o_out}, {29'h0, TE[i]});
      check({29'h0, o_out_n}, {29'h0, ~TE[i]});
    end
    pulse(3'h4, 3'h4, 3'h4);
    repeat (12) @(negedge i_clock);
    check({29'h0, o_out_unknown}, 32'h4);
    $display("truth table test done");
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clock);
      i_async_set <= AS[i];
      i_async_reset <= AR[i];
      i_ctl_unknown <= AU[i];
      repeat (12) @(negedge i_clock);
      check({26'h0, o_out_unknown, o_out}, {26'h0, AE[i]});
    end
    wr(`INIT_OFS, 32'h0000_0024);
    check({30'h0, resp}, {30'h0, `RESP_OKAY});
    repeat (4) @(negedge i_clock);
    check({26'h0, o_out_unknown, o_out}, 32'h22);
    rd(`STATUS_OFS);
    check(rd_q, 32'h0000_0042);
    wr(8'h20, 32'h0000_0000);
    check({30'h0, resp}, {30'h0, `RESP_SLVERR});
    $display("async and init test done");
    hold <= 4'h8;
    meas(3'h1, 3'h1, 3'h0, lat0);
    wr(`CFG_JK_OFS, 32'h3201_0105);
    rd(`CFG_JK_OFS);
    check(rd_q, 32'h3201_0105);
    meas(3'h1, 3'h0, 3'h1, lat);
    check(lat - lat0, 32'h7);
    meas(3'h1, 3'h1, 3'h0, lat);
    check(lat - lat0, 32'h6);
    $display("delay test done");
    summarize();
  end
endmodule : jk_toggle_sr_flip_flops_tb

// ---- verification/pin_driver.sv ----
// Driving logic model: clock pulses on the flop clock pins
`timescale 1ns/1ps
module pin_driver (
  // Bench clock and requests
  input wire logic i_clock,
  input wire logic [2:0] i_fire,
  input wire logic [3:0] i_hold,
  // Flop clock pins
  output logic [2:0] o_flop_clk = 3'h0
);
  logic [3:0] cnt_q = 4'h0;
  // Raise requested pins for i_hold cycles, always a known level
  always @(posedge i_clock) begin
    if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) o_flop_clk <= 3'h0;
    end else if (i_fire != 3'h0) begin
      o_flop_clk <= i_fire;
      cnt_q <= i_hold;
    end
  end
endmodule : pin_driver
